// *** src/pssb_defines.vh ***
// register map, encodings and timing constants for the system status bank
`ifndef PSSB_DEFINES_VH
`define PSSB_DEFINES_VH
// bus address space: word index, 8 bits
`define PSSB_AW 8
// flag word at index 0, one bit per flag, bit n = flag n
`define PSSB_A_FLAGS 8'h00
`define PSSB_B_FIRST 1
`define PSSB_B_NETOK 2
`define PSSB_B_TFAST 3
`define PSSB_B_TMED 4
`define PSSB_B_TSLOW 5
`define PSSB_B_IOOK 6
`define PSSB_B_ONE 7
`define PSSB_B_ZERO 8
`define PSSB_B_PAUSE 9
`define PSSB_B_RESUME 10
`define PSSB_B_FORCED 11
`define PSSB_B_FORCING 12
`define PSSB_B_RIOOK 13
// status words at their word indices
`define PSSB_A_OPSCR 8'h01
`define PSSB_A_ALMSCR 8'h02
`define PSSB_A_SYSSCR 8'h03
`define PSSB_A_SELFTEST 8'h04
`define PSSB_A_MODE 8'h05
`define PSSB_A_RATE_AVG 8'h06
`define PSSB_A_RATE_MIN 8'h07
`define PSSB_A_RATE_MAX 8'h08
`define PSSB_A_EDIT_LO 8'h09
`define PSSB_A_EDIT_HI 8'h0a
`define PSSB_A_LADSZ_LO 8'h0b
`define PSSB_A_LADSZ_HI 8'h0c
`define PSSB_A_IOSZ_LO 8'h11
`define PSSB_A_IOSZ_HI 8'h12
`define PSSB_A_NETSZ_LO 8'h13
`define PSSB_A_NETSZ_HI 8'h14
`define PSSB_A_SECSZ_LO 8'h15
`define PSSB_A_SECSZ_HI 8'h16
`define PSSB_A_LAD_CRC 8'h17
`define PSSB_A_IOTAB_CRC 8'h1a
`define PSSB_A_NETTAB_CRC 8'h1b
`define PSSB_A_SEC_CRC 8'h1c
`define PSSB_A_NODE_ID 8'h1d
`define PSSB_A_BITRATE 8'h1e
`define PSSB_A_NETMODE 8'h1f
`define PSSB_A_FKEY 8'h21
`define PSSB_A_SERPROT 8'h22
`define PSSB_A_SERNO_LO 8'h23
`define PSSB_A_SERNO_HI 8'h24
`define PSSB_A_MODEL 8'h25
`define PSSB_A_FW_REV 8'h26
`define PSSB_A_BOOT_REV 8'h27
`define PSSB_A_IMG_REV 8'h28
`define PSSB_A_VPIX 8'h29
`define PSSB_A_HPIX 8'h2a
`define PSSB_A_CAL_SEC 8'h2c
`define PSSB_A_CAL_MIN 8'h2d
`define PSSB_A_CAL_HOUR 8'h2e
`define PSSB_A_CAL_DATE 8'h2f
`define PSSB_A_CAL_MON 8'h30
// run state codes
`define PSSB_MODE_IDLE 16'h0000
`define PSSB_MODE_DOIO 16'h0001
`define PSSB_MODE_RUN 16'h0002
// limits
`define PSSB_RATE_MAX 16'h03e8
`define PSSB_NODE_MIN 16'h0001
`define PSSB_NODE_MAX 16'h00fd
`define PSSB_ALRM_MAX 16'h03ff
`define PSSB_SYS_MAX 16'h000e
`define PSSB_BITRATE_MAX 16'h0003
`define PSSB_NETMODE_MAX 16'h0003
`define PSSB_FKEY_MAX 16'h0001
`define PSSB_SERPROT_MAX 16'h0004
// timing
`define PSSB_CLK_HZ 50000000
`define PSSB_MS_HZ 1000
`define PSSB_FAST_HALF_MS 5
`define PSSB_MED_HALF_MS 50
`define PSSB_SLOW_HALF_MS 500
`endif

// *** src/pssb_status_bank.v ***
// system status bank: flags, status words, tick generators and register port
//
// Summary of operation
// - first-scan flag high only for first scan after entering run state
// - fieldbus-healthy flag follows the network health input
// - fast tick: 5 ms high, 5 ms low, free running
// - medium tick: 50 ms high, 50 ms low, free running
// - slow tick: 500 ms high, 500 ms low, one second period
// - local-expansion-configured flag follows expansion match input
// - pause-final-scan flag high only in last scan before pause
// - resume-first-scan flag high only in first scan of resume
// - points-overridden flag high while any point is forced
// - override-allowed flag high while forcing is enabled
// - remote-I/O-healthy flag follows remote I/O health input
// - 32-bit values: low half in lower word, high half above
// - run state word: 0 idle, 1 I/O only, 2 run
// - scan rate words scaled by ten, capped at 1000
// - bit rate code 0..3 for 125k, 250k, 500k, 1M
// - participation mode code 0..3
// - function key mode 0 momentary, 1 toggle
// - serial protocol code 0..4
// - primary node identifier kept between 1 and 253
// - alarm screen number 0 none, at most 1023
// - system screen number 0 none, at most 14
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "pssb_defines.vh"

module pssb_status_bank #(
   // model code value is arbitrary
   parameter MODEL_CODE = 16'h0a5a,
   parameter FW_REV = 16'h0000,
   parameter BOOT_REV = 16'h0000,
   parameter IMG_REV = 16'h0000,
   parameter VPIX = 16'h0000,
   parameter HPIX = 16'h0000,
   parameter MS_DIV = `PSSB_CLK_HZ / `PSSB_MS_HZ
) (
   // clock and reset
   input wire core_clk,
   input wire reset,
   // register port
   input wire [`PSSB_AW-1:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   // scan engine, same clock
   input wire scan_start,
   input wire [1:0] run_mode,
   input wire pause_pending,
   input wire resume_pending,
   input wire [15:0] cycle_rate_avg,
   input wire [15:0] cycle_rate_min,
   input wire [15:0] cycle_rate_max,
   // health and forcing pins, asynchronous
   input wire fieldbus_ok_pin,
   input wire expansion_ok_pin,
   input wire remote_io_ok_pin,
   input wire forced_any_pin,
   input wire forcing_enable_pin,
   // configuration and table data, same clock
   input wire [15:0] operator_screen,
   input wire [15:0] alarm_screen,
   input wire [15:0] system_screen,
   input wire [15:0] diag_result,
   input wire [31:0] program_length,
   input wire [31:0] io_table_length,
   input wire [31:0] net_table_length,
   input wire [31:0] sec_table_length,
   input wire [15:0] program_crc,
   input wire [15:0] io_table_crc,
   input wire [15:0] net_table_crc,
   input wire [15:0] sec_crc,
   input wire [15:0] node_id,
   input wire [15:0] bit_rate,
   input wire [15:0] participation_mode,
   input wire [15:0] function_key_mode,
   input wire [15:0] serial_protocol,
   input wire [31:0] serial_number,
   input wire [15:0] cal_sec,
   input wire [15:0] cal_min,
   input wire [15:0] cal_hour,
   input wire [15:0] cal_date,
   input wire [15:0] cal_mon,
   // flag, tick and edit value outputs
   output reg first_scan_flag,
   output reg pause_final_scan_flag,
   output reg resume_first_scan_flag,
   output reg tick_fast,
   output reg tick_medium,
   output reg tick_slow,
   output wire [31:0] field_edit_value
);

////////////////////////////////////////////////////////////////////////
// pin synchronisers
localparam NSYNC = 5;
wire [NSYNC-1:0] pin_in;
reg [NSYNC-1:0] sync_a;
reg [NSYNC-1:0] sync_b;
assign pin_in = {forcing_enable_pin, forced_any_pin, remote_io_ok_pin, expansion_ok_pin, fieldbus_ok_pin};

genvar gi;
generate
   for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge core_clk or posedge reset) begin
         if (reset) begin
            sync_a[gi] <= 1'b0;
            sync_b[gi] <= 1'b0;
         end else begin
            sync_a[gi] <= pin_in[gi];
            sync_b[gi] <= sync_a[gi];
         end
      end
   end
endgenerate

wire fieldbus_healthy_flag = sync_b[0];
wire local_expansion_configured = sync_b[1];
wire remote_io_healthy_flag = sync_b[2];
wire points_overridden_flag = sync_b[3];
wire override_allowed_flag = sync_b[4];

////////////////////////////////////////////////////////////////////////
// scan flags, updated at each scan start
reg was_run;
reg pause_seen;

always @(posedge core_clk or posedge reset) begin
   if (reset) begin
      was_run <= 1'b0;
      pause_seen <= 1'b0;
      first_scan_flag <= 1'b0;
      pause_final_scan_flag <= 1'b0;
      resume_first_scan_flag <= 1'b0;
   end else if (scan_start) begin
      was_run <= (run_mode == `PSSB_MODE_RUN);
      first_scan_flag <= (run_mode == `PSSB_MODE_RUN) && !was_run;
      pause_final_scan_flag <= pause_pending;
      resume_first_scan_flag <= resume_pending && pause_seen;
      if (pause_pending)
         pause_seen <= 1'b1;
      else if (resume_pending)
         pause_seen <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////
// millisecond enable and tick dividers
localparam FAST_CNT = `PSSB_FAST_HALF_MS;
localparam MED_CNT = `PSSB_MED_HALF_MS;
localparam SLOW_CNT = `PSSB_SLOW_HALF_MS;
reg [31:0] ms_cnt;
reg ms_en;
reg [9:0] fast_cnt;
reg [9:0] med_cnt;
reg [9:0] slow_cnt;

always @(posedge core_clk or posedge reset) begin
   if (reset) begin
      ms_cnt <= 32'h0;
      ms_en <= 1'b0;
   end else if (ms_cnt == MS_DIV - 1) begin
      ms_cnt <= 32'h0;
      ms_en <= 1'b1;
   end else begin
      ms_cnt <= ms_cnt + 32'h1;
      ms_en <= 1'b0;
   end
end

always @(posedge core_clk or posedge reset) begin
   if (reset) begin
      fast_cnt <= 10'h0;
      med_cnt <= 10'h0;
      slow_cnt <= 10'h0;
      tick_fast <= 1'b0;
      tick_medium <= 1'b0;
      tick_slow <= 1'b0;
   end else if (ms_en) begin
      if (fast_cnt == FAST_CNT - 1) begin
         fast_cnt <= 10'h0;
         tick_fast <= ~tick_fast;
      end else
         fast_cnt <= fast_cnt + 10'h1;
      if (med_cnt == MED_CNT - 1) begin
         med_cnt <= 10'h0;
         tick_medium <= ~tick_medium;
      end else
         med_cnt <= med_cnt + 10'h1;
      if (slow_cnt == SLOW_CNT - 1) begin
         slow_cnt <= 10'h0;
         tick_slow <= ~tick_slow;
      end else
         slow_cnt <= slow_cnt + 10'h1;
   end
end

////////////////////////////////////////////////////////////////////////
// edit buffer, the only writable word pair
reg [15:0] edit_lo;
reg [15:0] edit_hi;
assign field_edit_value = {edit_hi, edit_lo};

always @(posedge core_clk or posedge reset) begin
   if (reset) begin
      edit_lo <= 16'h0;
      edit_hi <= 16'h0;
   end else if (reg_wr) begin
      if (reg_addr == `PSSB_A_EDIT_LO)
         edit_lo <= reg_wdata;
      if (reg_addr == `PSSB_A_EDIT_HI)
         edit_hi <= reg_wdata;
   end
end

////////////////////////////////////////////////////////////////////////
// value clamps
function [15:0] clamp;
   input [15:0] v;
   input [15:0] lo;
   input [15:0] hi;
   begin
      if (v < lo)
         clamp = lo;
      else if (v > hi)
         clamp = hi;
      else
         clamp = v;
   end
endfunction

wire [15:0] mode_word = (run_mode == 2'd2) ? `PSSB_MODE_RUN :
   (run_mode == 2'd1) ? `PSSB_MODE_DOIO : `PSSB_MODE_IDLE;

wire [15:0] flag_word = {2'b00,
   remote_io_healthy_flag,
   override_allowed_flag,
   points_overridden_flag,
   resume_first_scan_flag,
   pause_final_scan_flag,
   1'b0,
   1'b1,
   local_expansion_configured,
   tick_slow,
   tick_medium,
   tick_fast,
   fieldbus_healthy_flag,
   first_scan_flag,
   1'b0};

////////////////////////////////////////////////////////////////////////
// read mux, data one cycle after the strobe, unmapped reads zero
reg [15:0] next_rdata;

always @* begin
   next_rdata = 16'h0;
   case (reg_addr)
      `PSSB_A_FLAGS: next_rdata = flag_word;
      `PSSB_A_OPSCR: next_rdata = operator_screen;
      `PSSB_A_ALMSCR: next_rdata = clamp(alarm_screen, 16'h0, `PSSB_ALRM_MAX);
      `PSSB_A_SYSSCR: next_rdata = clamp(system_screen, 16'h0, `PSSB_SYS_MAX);
      `PSSB_A_SELFTEST: next_rdata = diag_result;
      `PSSB_A_MODE: next_rdata = mode_word;
      `PSSB_A_RATE_AVG: next_rdata = clamp(cycle_rate_avg, 16'h0, `PSSB_RATE_MAX);
      `PSSB_A_RATE_MIN: next_rdata = clamp(cycle_rate_min, 16'h0, `PSSB_RATE_MAX);
      `PSSB_A_RATE_MAX: next_rdata = clamp(cycle_rate_max, 16'h0, `PSSB_RATE_MAX);
      `PSSB_A_EDIT_LO: next_rdata = edit_lo;
      `PSSB_A_EDIT_HI: next_rdata = edit_hi;
      `PSSB_A_LADSZ_LO: next_rdata = program_length[15:0];
      `PSSB_A_LADSZ_HI: next_rdata = program_length[31:16];
      `PSSB_A_IOSZ_LO: next_rdata = io_table_length[15:0];
      `PSSB_A_IOSZ_HI: next_rdata = io_table_length[31:16];
      `PSSB_A_NETSZ_LO: next_rdata = net_table_length[15:0];
      `PSSB_A_NETSZ_HI: next_rdata = net_table_length[31:16];
      `PSSB_A_SECSZ_LO: next_rdata = sec_table_length[15:0];
      `PSSB_A_SECSZ_HI: next_rdata = sec_table_length[31:16];
      `PSSB_A_LAD_CRC: next_rdata = program_crc;
      `PSSB_A_IOTAB_CRC: next_rdata = io_table_crc;
      `PSSB_A_NETTAB_CRC: next_rdata = net_table_crc;
      `PSSB_A_SEC_CRC: next_rdata = sec_crc;
      `PSSB_A_NODE_ID: next_rdata = clamp(node_id, `PSSB_NODE_MIN, `PSSB_NODE_MAX);
      `PSSB_A_BITRATE: next_rdata = clamp(bit_rate, 16'h0, `PSSB_BITRATE_MAX);
      `PSSB_A_NETMODE: next_rdata = clamp(participation_mode, 16'h0, `PSSB_NETMODE_MAX);
      `PSSB_A_FKEY: next_rdata = clamp(function_key_mode, 16'h0, `PSSB_FKEY_MAX);
      `PSSB_A_SERPROT: next_rdata = clamp(serial_protocol, 16'h0, `PSSB_SERPROT_MAX);
      `PSSB_A_SERNO_LO: next_rdata = serial_number[15:0];
      `PSSB_A_SERNO_HI: next_rdata = serial_number[31:16];
      `PSSB_A_MODEL: next_rdata = MODEL_CODE;
      `PSSB_A_FW_REV: next_rdata = FW_REV;
      `PSSB_A_BOOT_REV: next_rdata = BOOT_REV;
      `PSSB_A_IMG_REV: next_rdata = IMG_REV;
      `PSSB_A_VPIX: next_rdata = VPIX;
      `PSSB_A_HPIX: next_rdata = HPIX;
      `PSSB_A_CAL_SEC: next_rdata = cal_sec;
      `PSSB_A_CAL_MIN: next_rdata = cal_min;
      `PSSB_A_CAL_HOUR: next_rdata = cal_hour;
      `PSSB_A_CAL_DATE: next_rdata = cal_date;
      `PSSB_A_CAL_MON: next_rdata = cal_mon;
      default: next_rdata = 16'h0;
   endcase
end

// rdata holds zero except in the cycle after a read
always @(posedge core_clk or posedge reset) begin
   if (reset)
      reg_rdata <= 16'h0;
   else if (reg_rd)
      reg_rdata <= next_rdata;
   else
      reg_rdata <= 16'h0;
end

endmodule

// *** tb/pssb_status_bank_checker.sv ***
// checker: register port and scan flag assertions for the status bank
`timescale 1ns/1ps
module pssb_checker (
   // clock and reset
   input wire core_clk,
   input wire reset,
   // register port
   input wire [7:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   // scan side
   input wire scan_start,
   input wire [1:0] run_mode,
   input wire pause_pending,
   input wire first_scan_flag,
   input wire pause_final_scan_flag,
   input wire [31:0] field_edit_value
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////
   AST_FIRST_RUN_ONLY: assert property (scan_start && run_mode != 2'd2 |=> !first_scan_flag)
      else $error("first scan flag outside run");
   AST_FIRST_HOLD: assert property (!scan_start |=> $stable(first_scan_flag))
      else $error("first scan flag moved mid scan");
   AST_PAUSE_FLAG: assert property (scan_start |=> pause_final_scan_flag == $past(pause_pending))
      else $error("pause flag wrong");
   AST_MODE_WORD: assert property (reg_rd && reg_addr == 8'h05 |=>
      reg_rdata == (($past(run_mode) == 2'd3) ? 16'h0000 : {14'h0000, $past(run_mode)}))
      else $error("run state word wrong");
   AST_ONE_ZERO: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata[7] && !reg_rdata[8])
      else $error("constant bits wrong");
   AST_EDIT_LO: assert property (reg_wr && reg_addr == 8'h09 |=> field_edit_value[15:0] == $past(reg_wdata))
      else $error("edit low word wrong");
   AST_EDIT_HI: assert property (reg_wr && reg_addr == 8'h0a |=> field_edit_value[31:16] == $past(reg_wdata))
      else $error("edit high word wrong");
   AST_NODE_RANGE: assert property (reg_rd && reg_addr == 8'h1d |=> reg_rdata inside {[1:253]})
      else $error("node id out of range");
   AST_SYS_RANGE: assert property (reg_rd && reg_addr == 8'h03 |=> reg_rdata <= 16'h000e)
      else $error("system screen out of range");
   AST_RATE_RANGE: assert property (reg_rd && reg_addr inside {[6:8]} |=> reg_rdata <= 16'h03e8)
      else $error("scan rate out of range");
   cover property (scan_start && run_mode == 2'd2);
   cover property (reg_wr && reg_addr == 8'h0a);
   cover property (pause_final_scan_flag ##1 !pause_final_scan_flag);
endmodule
bind pssb_status_bank pssb_checker pssb_checker_i (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scan_start(scan_start),
   .run_mode(run_mode), .pause_pending(pause_pending), .first_scan_flag(first_scan_flag),
   .pause_final_scan_flag(pause_final_scan_flag), .field_edit_value(field_edit_value));

// *** tb/test_pssb_status_bank.sv ***
// testbench: flags, scan markers, words, clamps and ticks of the status bank
`timescale 1ns/1ps
module test_pssb_status_bank;
   reg core_clk = 1'b0;
   reg reset = 1'b1;
   reg [7:0] reg_addr = 8'h00;
   reg [15:0] reg_wdata = 16'h0000;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg scan_start = 1'b0;
   reg [1:0] run_mode = 2'd0;
   reg pause_pending = 1'b0;
   reg resume_pending = 1'b0;
   reg [4:0] hp = 5'h00;
   reg [15:0] cv = 16'h0000;
   reg [31:0] wv = 32'h5a3c96e1;
   reg [15:0] msk = 16'hffff;
   wire [15:0] reg_rdata;
   wire fs, pf, rf;
   wire [2:0] tk;
   wire [31:0] ev;
   int n_fail = 0;
   int tests_run = 0;
   logic [7:0] wide_a [0:4] = '{8'h0b, 8'h11, 8'h13, 8'h15, 8'h23};
   logic [7:0] pass_a [0:6] = '{8'h01, 8'h04, 8'h17, 8'h1a, 8'h1c, 8'h2c, 8'h30};
   logic [7:0] cl_a [0:8] = '{8'h06, 8'h07, 8'h08, 8'h02, 8'h03, 8'h1e, 8'h1f, 8'h21, 8'h22};
   logic [15:0] cl_m [0:8] = '{16'h03e8, 16'h03e8, 16'h03e8, 16'h03ff, 16'h000e, 16'h0003, 16'h0003, 16'h0001, 16'h0004};
   logic [15:0] vals [0:11] = '{16'h0, 16'h1, 16'h2, 16'h4, 16'h5, 16'he, 16'hf, 16'hfd, 16'hfe, 16'h3e9, 16'h400, 16'hffff};
   always #10 core_clk = ~core_clk;
   pssb_status_bank #(.MS_DIV(4)) pssb_status_bank_i (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scan_start(scan_start),
      .run_mode(run_mode), .pause_pending(pause_pending), .resume_pending(resume_pending), .cycle_rate_avg(cv),
      .cycle_rate_min(cv), .cycle_rate_max(cv), .fieldbus_ok_pin(hp[0]), .expansion_ok_pin(hp[1]),
      .remote_io_ok_pin(hp[2]), .forced_any_pin(hp[3]), .forcing_enable_pin(hp[4]), .operator_screen(wv[15:0]),
      .alarm_screen(cv), .system_screen(cv), .diag_result(wv[15:0]), .program_length(wv), .io_table_length(wv),
      .net_table_length(wv), .sec_table_length(wv), .program_crc(wv[15:0]), .io_table_crc(wv[15:0]),
      .net_table_crc(cv), .sec_crc(wv[15:0]), .node_id(cv), .bit_rate(cv), .participation_mode(cv),
      .function_key_mode(cv), .serial_protocol(cv), .serial_number(wv), .cal_sec(wv[15:0]), .cal_min(cv),
      .cal_hour(cv), .cal_date(cv), .cal_mon(wv[15:0]),
      .first_scan_flag(fs), .pause_final_scan_flag(pf), .resume_first_scan_flag(rf), .tick_fast(tk[0]),
      .tick_medium(tk[1]), .tick_slow(tk[2]), .field_edit_value(ev));
   ////////////////////////////////////////////////////////////////
   function [15:0] mn(input [15:0] v, input [15:0] m);
      mn = (v > m) ? m : v;
   endfunction
   task chk(input [15:0] got, input [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task rd(input [7:0] a, input [15:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata & msk, e);
   endtask
   task wr(input [7:0] a, input [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task scan(input [1:0] m, input p, input r, input [2:0] e);
      @(posedge core_clk);
      run_mode <= m;
      pause_pending <= p;
      resume_pending <= r;
      scan_start <= 1'b1;
      @(posedge core_clk);
      scan_start <= 1'b0;
      @(posedge core_clk);
      #1 chk({13'h0000, fs, pf, rf}, {13'h0000, e});
   endtask
   task wt(input int k, input logic v);
      int n;
      for (n = 0; tk[k] !== v && n < 9000; n++) begin
         @(posedge core_clk);
         #1;
      end
   endtask
   task span(input int k, input logic v, input int half);
      int n;
      for (n = 0; tk[k] === v && n < 9000; n++) begin
         @(posedge core_clk);
         #1;
      end
      chk(n[15:0], half[15:0]);
   endtask
   ////////////////////////////////////////////////////////////////
   task t_flags;
      int i;
      reg [4:0] h;
      msk = 16'hffc7;
      for (i = 0; i < 7; i++) begin
         h = (i < 5) ? (5'h01 << i) : ((i == 5) ? 5'h1f : 5'h00);
         @(posedge core_clk);
         hp <= h;
         repeat (3) @(posedge core_clk);
         rd(8'h00, {2'b00, h[2], h[4], h[3], 3'b000, 1'b1, h[1], 3'b000, h[0], 2'b00});
      end
      msk = 16'hffff;
      $display("flag test done");
   endtask
   task t_scan;
      scan(2'd0, 1'b0, 1'b0, 3'b000);
      scan(2'd2, 1'b0, 1'b0, 3'b100);
      scan(2'd2, 1'b0, 1'b0, 3'b000);
      scan(2'd2, 1'b0, 1'b1, 3'b000);
      scan(2'd2, 1'b1, 1'b0, 3'b010);
      scan(2'd2, 1'b0, 1'b1, 3'b001);
      scan(2'd2, 1'b0, 1'b1, 3'b000);
      scan(2'd1, 1'b0, 1'b0, 3'b000);
      scan(2'd2, 1'b0, 1'b0, 3'b100);
      $display("scan test done");
   endtask
   task t_mode;
      int i;
      for (i = 0; i < 4; i++) begin
         @(posedge core_clk);
         run_mode <= i[1:0];
         wr(8'h05, 16'h0001);
         rd(8'h05, (i == 3) ? 16'h0000 : i[15:0]);
      end
      rd(8'hff, 16'h0000);
      $display("mode test done");
   endtask
   task t_clamp;
      int i;
      int j;
      for (i = 0; i < 12; i++) begin
         @(posedge core_clk);
         cv <= vals[i];
         for (j = 0; j < 9; j++)
            rd(cl_a[j], mn(vals[i], cl_m[j]));
         rd(8'h1d, (vals[i] == 16'h0) ? 16'h0001 : mn(vals[i], 16'h00fd));
      end
      $display("clamp test done");
   endtask
   task t_wide;
      int j;
      for (j = 0; j < 5; j++) begin
         rd(wide_a[j], wv[15:0]);
         rd(wide_a[j] + 8'h01, wv[31:16]);
      end
      for (j = 0; j < 7; j++)
         rd(pass_a[j], wv[15:0]);
      wr(8'h09, 16'hbeef);
      wr(8'h0a, 16'hcafe);
      #1 chk(ev[15:0], 16'hbeef);
      chk(ev[31:16], 16'hcafe);
      rd(8'h0a, 16'hcafe);
      $display("wide test done");
   endtask
   task t_ticks;
      int k;
      int half [0:2];
      half = '{20, 200, 2000};
      for (k = 0; k < 3; k++) begin
         wt(k, 1'b0);
         wt(k, 1'b1);
         span(k, 1'b1, half[k]);
         span(k, 1'b0, half[k]);
      end
      $display("tick test done");
   endtask
   task conclude;
      $display("checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      t_flags;
      t_scan;
      t_mode;
      t_clamp;
      t_wide;
      t_ticks;
      conclude;
   end
   initial begin
      repeat (40000) @(posedge core_clk);
      n_fail++;
      conclude;
   end
endmodule
